// ### pwr_pkg.sv
package pwr_pkg;
    // I/O space of the core
    localparam logic [5:0] SLEEP_CONTROL_ADDR = 6'h33;
    localparam logic [5:0] MCU_CONTROL_ADDR = 6'h35;
    localparam logic [5:0] RESET_CAUSE_ADDR = 6'h34;
    localparam logic [5:0] POWER_GATING_ADDR = 6'h24;
    localparam logic [7:0] SLEEP_CONTROL_RESET = 8'h00;
    localparam logic [7:0] MCU_CONTROL_RESET = 8'h00;
    localparam logic [7:0] POWER_GATING_RESET = 8'h00;
    localparam logic [7:0] SLEEP_CONTROL_MASK = 8'h0f;
    localparam logic [7:0] POWER_GATING_MASK = 8'h1f;
    localparam logic [7:0] RESET_CAUSE_MASK = 8'h1f;
    // Field positions
    localparam int SLEEP_ARM_BIT = 0;
    localparam int SLEEP_MODE_LSB = 1;
    localparam int BROWNOUT_SLEEP_OFF_BIT = 6;
    localparam int BROWNOUT_SLEEP_OFF_UNLOCK_BIT = 5;
    localparam int ADC_GATE_BIT = 0;
    localparam int USART_GATE_BIT = 1;
    localparam int SPI_GATE_BIT = 2;
    localparam int TIMER1_GATE_BIT = 3;
    localparam int LCD_GATE_BIT = 4;
    localparam int POR_FLAG_BIT = 0;
    localparam int EXT_FLAG_BIT = 1;
    localparam int BOD_FLAG_BIT = 2;
    localparam int WATCHDOG_RESET_FLAG_BIT = 3;
    localparam int JTAG_FLAG_BIT = 4;
    // Timing counts in core clocks
    localparam logic [2:0] BROWNOUT_SLEEP_OFF_UNLOCK_CYCLES = 3'd4;
    localparam logic [1:0] BROWNOUT_SLEEP_OFF_ACTIVE_CYCLES = 2'd3;
    localparam logic [9:0] RESET_TOUT_BASE = 10'd16;
    // Sleep modes
    typedef enum logic [2:0] {
        MODE_IDLE = 3'b000,
        MODE_ADC_NR = 3'b001,
        MODE_POWER_DOWN = 3'b010,
        MODE_POWER_SAVE = 3'b011,
        MODE_STANDBY = 3'b110
    } sleep_mode_t;
    // Controller APB map
    localparam logic [7:0] CMD_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [2:0] OP_WRITE = 3'd0;
    localparam logic [2:0] OP_READ = 3'd1;
    localparam logic [2:0] OP_SLEEP = 3'd2;
    localparam logic [2:0] OP_BROWNOUT_SLEEP_OFF = 3'd3;
endpackage

// ### pwr_link_if.sv
`timescale 1ns/1ns
interface pwr_link_if;
    logic [5:0] io_addr;
    logic [7:0] io_wdata;
    logic io_we;
    logic io_re;
    logic [7:0] io_rdata;
    logic sleep_exec;
    logic sleeping;
    logic core_reset;
    modport device (input io_addr, input io_wdata, input io_we, input io_re, input sleep_exec,
                    output io_rdata, output sleeping, output core_reset);
    modport core (output io_addr, output io_wdata, output io_we, output io_re, output sleep_exec,
                  input io_rdata, input sleeping, input core_reset);
endinterface

// ### pwr_device.sv
// What this block does
// - Mode field selects five modes, three reserved
// - Sleep control: low nibble RW, upper zero
// - Sleep instruction sleeps only when armed
// - Software arms just before, disarms after wake
// - Sleep-off bit needs unlock then write
// - Sleep-off effective after three cycles only
// - Sleep-off bit self-clears after four cycles
// - Gating bits 7 to 5 read zero
// - Bit 4 shuts down LCD controller
// - Bit 3 freezes timer 1, resumes
// - Bit 2 stops SPI clock
// - Bit 1 stops USART clock
// - Bit 0 shuts ADC, blocks comparator mux
// - Reset loads every register's initial value except the cause flags
// - Ports reset at once without clock
// - Delay counter stretches reset after sources
// - Internal reset combines five sources
// - External reset needs long low pulse; here any low sampled at one clock edge resets
// - Watchdog expiry while enabled resets
// - Brown-out resets only when detector enabled
// - JTAG reset held while register is one
// - Power-on re-assert resets without delay
// - Per-cause flags, write zero clears
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
module pwr_device (
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic SRST_IN,
    // Core side
    pwr_link_if.device link,
    // Reset sources
    input wire logic POR_IN,
    input wire logic EXT_RESET_N_IN,
    input wire logic WDT_EXPIRE_IN,
    input wire logic WDT_ENABLE_IN,
    input wire logic BOD_LOW_IN,
    input wire logic BOD_ENABLE_IN,
    input wire logic JTAG_RESET_IN,
    // Configuration settings
    input wire logic [1:0] STARTUP_TIME_SELECT_IN,
    input wire logic [3:0] CLOCK_SOURCE_SELECT_IN,
    // Wake-up
    input wire logic WAKE_IN,
    // Reset outputs
    output logic PORT_RESET_OUT,
    output logic INT_RESET_OUT,
    // Sleep outputs
    output logic SLEEP_OUT,
    output logic [2:0] SLEEP_MODE_OUT,
    output logic BOD_OFF_OUT,
    // Peripheral gates
    output logic LCD_GATE_OUT,
    output logic TIMER1_GATE_OUT,
    output logic SPI_GATE_OUT,
    output logic USART_GATE_OUT,
    output logic ADC_GATE_OUT,
    output logic ADC_MUX_FREE_OUT
);
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic por_s;
    logic ext_s;
    logic wdt_s;
    logic bod_s;
    logic jtag_s;
    logic any_source;
    logic [9:0] tout_cnt;
    logic int_rst;
    logic rst_all;
    logic [7:0] sleep_control;
    logic [7:0] mcu_control;
    logic [7:0] power_gating;
    logic [4:0] reset_cause_flags;
    logic [2:0] unlock_cnt;
    logic [1:0] brownout_sleep_off_age;
    logic brownout_sleep_off_effective;
    logic sleeping;
    logic [2:0] mode;
    logic bod_off;
    logic [7:0] rdata;
    logic wr_sleep;
    logic wr_mcu;
    logic wr_gate;
    logic wr_cause;
    logic mode_valid;
    logic [9:0] tout_value;

    // Raw sources drive the port reset directly, not through the synchronizer, as it must act with no clock
    assign PORT_RESET_OUT = POR_IN | ~EXT_RESET_N_IN | (WDT_EXPIRE_IN & WDT_ENABLE_IN)
                            | (BOD_LOW_IN & BOD_ENABLE_IN) | JTAG_RESET_IN;

    always_ff @(posedge MCLK_IN)
    begin
        if (SRST_IN)
        begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
        end
        else
        begin
            sync1 <= {JTAG_RESET_IN, BOD_LOW_IN & BOD_ENABLE_IN, WDT_EXPIRE_IN & WDT_ENABLE_IN,
                      ~EXT_RESET_N_IN, POR_IN};
            sync2 <= sync1;
        end
    end

    assign por_s = sync2[0];
    assign ext_s = sync2[1];
    assign wdt_s = sync2[2];
    assign bod_s = sync2[3];
    assign jtag_s = sync2[4];
    assign any_source = por_s | ext_s | wdt_s | bod_s | jtag_s;

    // Time-out grows with the start-up select; the clock source adds a little
    assign tout_value = 10'((pwr_pkg::RESET_TOUT_BASE + {6'h00, CLOCK_SOURCE_SELECT_IN}) << STARTUP_TIME_SELECT_IN);

    always_ff @(posedge MCLK_IN)
    begin
        if (SRST_IN)
            tout_cnt <= pwr_pkg::RESET_TOUT_BASE;
        else if (any_source)
            tout_cnt <= tout_value;
        else if (tout_cnt != 10'h000)
            tout_cnt <= tout_cnt - 10'd1;
    end

    // A returning source reasserts at once, not through the counter
    assign int_rst = any_source | (tout_cnt != 10'h000);
    assign rst_all = SRST_IN | int_rst;
    assign INT_RESET_OUT = int_rst;
    assign link.core_reset = int_rst;

    assign wr_sleep = link.io_we && link.io_addr == pwr_pkg::SLEEP_CONTROL_ADDR;
    assign wr_mcu = link.io_we && link.io_addr == pwr_pkg::MCU_CONTROL_ADDR;
    assign wr_gate = link.io_we && link.io_addr == pwr_pkg::POWER_GATING_ADDR;
    assign wr_cause = link.io_we && link.io_addr == pwr_pkg::RESET_CAUSE_ADDR;

    always_ff @(posedge MCLK_IN)
    begin
        if (rst_all)
            sleep_control <= pwr_pkg::SLEEP_CONTROL_RESET;
        else if (wr_sleep)
            sleep_control <= link.io_wdata & pwr_pkg::SLEEP_CONTROL_MASK;
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (rst_all)
            power_gating <= pwr_pkg::POWER_GATING_RESET;
        else if (wr_gate)
            power_gating <= link.io_wdata & pwr_pkg::POWER_GATING_MASK;
    end

    // Unlock window: opened by writing both bits one
    always_ff @(posedge MCLK_IN)
    begin
        if (rst_all)
            unlock_cnt <= 3'd0;
        else if (wr_mcu && link.io_wdata[pwr_pkg::BROWNOUT_SLEEP_OFF_BIT] && link.io_wdata[pwr_pkg::BROWNOUT_SLEEP_OFF_UNLOCK_BIT])
            unlock_cnt <= pwr_pkg::BROWNOUT_SLEEP_OFF_UNLOCK_CYCLES;
        else if (unlock_cnt != 3'd0)
            unlock_cnt <= unlock_cnt - 3'd1;
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (rst_all)
        begin
            mcu_control <= pwr_pkg::MCU_CONTROL_RESET;
            brownout_sleep_off_age <= 2'd0;
        end
        else
        begin
            if (wr_mcu)
            begin
                mcu_control[4:0] <= link.io_wdata[4:0];
                mcu_control[7] <= link.io_wdata[7];
                mcu_control[pwr_pkg::BROWNOUT_SLEEP_OFF_UNLOCK_BIT] <= link.io_wdata[pwr_pkg::BROWNOUT_SLEEP_OFF_UNLOCK_BIT];
            end
            else if (unlock_cnt == 3'd1)
                mcu_control[pwr_pkg::BROWNOUT_SLEEP_OFF_UNLOCK_BIT] <= 1'b0;
            if (wr_mcu && unlock_cnt != 3'd0 && link.io_wdata[pwr_pkg::BROWNOUT_SLEEP_OFF_BIT]
                && !link.io_wdata[pwr_pkg::BROWNOUT_SLEEP_OFF_UNLOCK_BIT])
            begin
                mcu_control[pwr_pkg::BROWNOUT_SLEEP_OFF_BIT] <= 1'b1;
                brownout_sleep_off_age <= 2'd0;
            end
            else if (mcu_control[pwr_pkg::BROWNOUT_SLEEP_OFF_BIT])
            begin
                brownout_sleep_off_age <= brownout_sleep_off_age + 2'd1;
                if (brownout_sleep_off_age == pwr_pkg::BROWNOUT_SLEEP_OFF_ACTIVE_CYCLES)
                    mcu_control[pwr_pkg::BROWNOUT_SLEEP_OFF_BIT] <= 1'b0;
            end
        end
    end

    // Live for one cycle: the third after setting, before self-clear
    assign brownout_sleep_off_effective = mcu_control[pwr_pkg::BROWNOUT_SLEEP_OFF_BIT]
                            && brownout_sleep_off_age == pwr_pkg::BROWNOUT_SLEEP_OFF_ACTIVE_CYCLES;

    // Flags are not cleared by the internal reset, else the cause would be lost
    always_ff @(posedge MCLK_IN)
    begin
        if (SRST_IN)
            reset_cause_flags <= 5'h00;
        else if (por_s)
            reset_cause_flags <= 5'h01 << pwr_pkg::POR_FLAG_BIT;
        else
            reset_cause_flags <= ((wr_cause ? (reset_cause_flags & link.io_wdata[4:0]) : reset_cause_flags)
                                 | {jtag_s, wdt_s, bod_s, ext_s, 1'b0});
    end

    always_comb
    begin
        case (sleep_control[3:1])
            pwr_pkg::MODE_IDLE, pwr_pkg::MODE_ADC_NR, pwr_pkg::MODE_POWER_DOWN,
            pwr_pkg::MODE_POWER_SAVE, pwr_pkg::MODE_STANDBY: mode_valid = 1'b1;
            default: mode_valid = 1'b0;
        endcase
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (rst_all)
        begin
            sleeping <= 1'b0;
            mode <= 3'b000;
            bod_off <= 1'b0;
        end
        else if (sleeping)
        begin
            if (WAKE_IN)
            begin
                sleeping <= 1'b0;
                bod_off <= 1'b0;
            end
        end
        else if (link.sleep_exec && sleep_control[pwr_pkg::SLEEP_ARM_BIT] && mode_valid)
        begin
            sleeping <= 1'b1;
            mode <= sleep_control[3:1];
            bod_off <= brownout_sleep_off_effective;
        end
    end

    always_comb
    begin
        case (link.io_addr)
            pwr_pkg::SLEEP_CONTROL_ADDR: rdata = sleep_control;
            pwr_pkg::MCU_CONTROL_ADDR: rdata = mcu_control;
            pwr_pkg::POWER_GATING_ADDR: rdata = power_gating;
            pwr_pkg::RESET_CAUSE_ADDR: rdata = {3'b000, reset_cause_flags};
            default: rdata = 8'h00;
        endcase
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (SRST_IN)
            link.io_rdata <= 8'h00;
        else if (link.io_re)
            link.io_rdata <= rdata;
    end

    assign link.sleeping = sleeping;
    assign SLEEP_OUT = sleeping;
    assign SLEEP_MODE_OUT = mode;
    assign BOD_OFF_OUT = bod_off;
    // Gates freeze the peripheral clock; state is kept, so clearing resumes
    assign LCD_GATE_OUT = power_gating[pwr_pkg::LCD_GATE_BIT];
    assign TIMER1_GATE_OUT = power_gating[pwr_pkg::TIMER1_GATE_BIT];
    assign SPI_GATE_OUT = power_gating[pwr_pkg::SPI_GATE_BIT];
    assign USART_GATE_OUT = power_gating[pwr_pkg::USART_GATE_BIT];
    assign ADC_GATE_OUT = power_gating[pwr_pkg::ADC_GATE_BIT];
    assign ADC_MUX_FREE_OUT = ~power_gating[pwr_pkg::ADC_GATE_BIT];
endmodule

// ### pwr_core.sv
`timescale 1ns/1ns
module pwr_core (
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic SRST_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Device side
    pwr_link_if.core link
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ACCESS = 3'b001,
        S_SLEEP = 3'b011,
        S_WAIT = 3'b010,
        S_DISARM = 3'b110,
        S_BODS2 = 3'b111
    } core_state_t;

    core_state_t state;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [2:0] op;
    logic [2:0] mode;
    logic [7:0] rdata;
    logic read_pending;
    logic wr_cmd;
    logic mapped;

    assign mapped = PADDR_IN == pwr_pkg::CMD_OFFSET || PADDR_IN == pwr_pkg::STATUS_OFFSET;
    assign wr_cmd = PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == pwr_pkg::CMD_OFFSET
                    && state == S_IDLE;
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;

    always_ff @(posedge MCLK_IN)
    begin
        if (SRST_IN)
            PRDATA_OUT <= 32'h0000_0000;
        else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN && PADDR_IN == pwr_pkg::STATUS_OFFSET)
            // Busy spans the read capture cycle, so status never shows stale data
            PRDATA_OUT <= {14'h0000, link.core_reset, link.sleeping, rdata, 7'h00, state != S_IDLE || read_pending};
        else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN && PADDR_IN == pwr_pkg::CMD_OFFSET)
            PRDATA_OUT <= {9'h000, mode, 1'b0, op, wdata, 2'b00, addr};
        else if (PSEL_IN && !PENABLE_IN)
            PRDATA_OUT <= 32'h0000_0000;
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (SRST_IN || link.core_reset)
        begin
            state <= S_IDLE;
            addr <= 6'h00;
            wdata <= 8'h00;
            op <= 3'd0;
            mode <= 3'd0;
        end
        else
        begin
            case (state)
                S_IDLE:
                    if (wr_cmd)
                    begin
                        addr <= PWDATA_IN[5:0];
                        wdata <= PWDATA_IN[15:8];
                        op <= PWDATA_IN[18:16];
                        mode <= PWDATA_IN[22:20];
                        state <= S_ACCESS;
                    end
                S_ACCESS:
                    if (op == pwr_pkg::OP_SLEEP)
                        state <= S_SLEEP;
                    else if (op == pwr_pkg::OP_BROWNOUT_SLEEP_OFF)
                        state <= S_BODS2;
                    else
                        state <= S_IDLE;
                // Second write follows the unlock on the very next cycle
                S_BODS2: state <= S_IDLE;
                S_SLEEP: state <= S_WAIT;
                S_WAIT:
                    if (!link.sleeping)
                        state <= S_DISARM;
                S_DISARM: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    always_comb
    begin
        link.io_addr = addr;
        link.io_wdata = wdata;
        link.io_we = 1'b0;
        link.io_re = 1'b0;
        link.sleep_exec = 1'b0;
        case (state)
            S_ACCESS:
                case (op)
                    pwr_pkg::OP_WRITE: link.io_we = 1'b1;
                    pwr_pkg::OP_READ: link.io_re = 1'b1;
                    pwr_pkg::OP_SLEEP:
                    begin
                        // Arm right before the sleep instruction
                        link.io_addr = pwr_pkg::SLEEP_CONTROL_ADDR;
                        link.io_wdata = {4'h0, mode, 1'b1};
                        link.io_we = 1'b1;
                    end
                    pwr_pkg::OP_BROWNOUT_SLEEP_OFF:
                    begin
                        link.io_addr = pwr_pkg::MCU_CONTROL_ADDR;
                        link.io_wdata = wdata | 8'h60;
                        link.io_we = 1'b1;
                    end
                    default: link.io_we = 1'b0;
                endcase
            S_BODS2:
            begin
                link.io_addr = pwr_pkg::MCU_CONTROL_ADDR;
                link.io_wdata = (wdata | 8'h40) & 8'hdf;
                link.io_we = 1'b1;
            end
            S_SLEEP: link.sleep_exec = 1'b1;
            S_DISARM:
            begin
                link.io_addr = pwr_pkg::SLEEP_CONTROL_ADDR;
                link.io_wdata = {4'h0, mode, 1'b0};
                link.io_we = 1'b1;
            end
            default: link.io_we = 1'b0;
        endcase
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (SRST_IN)
            read_pending <= 1'b0;
        else
            read_pending <= state == S_ACCESS && op == pwr_pkg::OP_READ;
    end

    always_ff @(posedge MCLK_IN)
    begin
        if (SRST_IN)
            rdata <= 8'h00;
        else if (read_pending)
            rdata <= link.io_rdata;
    end
endmodule

// ### pwr_checker.sv
`timescale 1ns/1ns
module pwr_checker (
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic SRST_IN,
    // Link signals
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_we,
    input wire logic io_re,
    input wire logic [7:0] io_rdata,
    input wire logic sleep_exec,
    input wire logic sleeping,
    input wire logic core_reset
);
    logic [7:0] sc;
    logic [7:0] pg;
    logic [3:0] age;
    logic [5:0] hi_len;
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (SRST_IN);
    // Shadows of what the core wrote, cleared with the device registers
    always_ff @(posedge MCLK_IN)
    begin
        if (SRST_IN || core_reset)
        begin
            sc <= 8'h00;
            pg <= 8'h00;
        end
        else if (io_we && io_addr == pwr_pkg::SLEEP_CONTROL_ADDR)
            sc <= io_wdata;
        else if (io_we && io_addr == pwr_pkg::POWER_GATING_ADDR)
            pg <= io_wdata;
    end
    // Saturates so that an old set write stays quiet
    always_ff @(posedge MCLK_IN)
    begin
        if (SRST_IN)
            age <= 4'hf;
        else if (io_we && io_addr == pwr_pkg::MCU_CONTROL_ADDR && io_wdata[6:5] == 2'b10)
            age <= 4'h0;
        else if (age != 4'hf)
            age <= age + 4'h1;
    end
    always_ff @(posedge MCLK_IN)
    begin
        if (SRST_IN || !core_reset)
            hi_len <= 6'h00;
        else if (hi_len != 6'h3f)
            hi_len <= hi_len + 6'h01;
    end
    sequence s_sleep_start;
        sleep_exec ##1 sleeping;
    endsequence
    sequence s_disarm;
        io_we && io_addr == pwr_pkg::SLEEP_CONTROL_ADDR && !io_wdata[0];
    endsequence
    property p_sleep_cause;
        $rose(sleeping) |-> $past(sleep_exec);
    endproperty
    a_sleep_cause: assert property (p_sleep_cause) else $error("sleep without instruction");
    property p_sleep_enter;
        sleep_exec && sc[0] && (sc[3:1] inside {3'b000, 3'b001, 3'b010, 3'b011, 3'b110}) |-> s_sleep_start;
    endproperty
    a_sleep_enter: assert property (p_sleep_enter) else $error("armed sleep not entered");
    property p_sleep_reserved;
        sleep_exec && (sc[3:1] inside {3'b100, 3'b101, 3'b111}) |=> !sleeping;
    endproperty
    a_sleep_reserved: assert property (p_sleep_reserved) else $error("reserved mode slept");
    property p_arm_first;
        sleep_exec |-> sc[0];
    endproperty
    a_arm_first: assert property (p_arm_first) else $error("sleep issued unarmed");
    property p_disarm;
        $fell(sleeping) && !core_reset |-> ##[0:2] s_disarm;
    endproperty
    a_disarm: assert property (p_disarm) else $error("no disarm after wake");
    property p_sc_read;
        io_re && io_addr == pwr_pkg::SLEEP_CONTROL_ADDR |=> io_rdata == (sc & 8'h0f);
    endproperty
    a_sc_read: assert property (p_sc_read) else $error("sleep control read wrong");
    property p_pg_read;
        io_re && io_addr == pwr_pkg::POWER_GATING_ADDR |=> io_rdata == (pg & 8'h1f);
    endproperty
    a_pg_read: assert property (p_pg_read) else $error("power gating read wrong");
    property p_brownout_sleep_off_clear;
        io_re && io_addr == pwr_pkg::MCU_CONTROL_ADDR && age >= 4'h4 |=> !io_rdata[6];
    endproperty
    a_brownout_sleep_off_clear: assert property (p_brownout_sleep_off_clear) else $error("sleep-off bit stuck");
    property p_reset_sleep;
        core_reset |=> !sleeping;
    endproperty
    a_reset_sleep: assert property (p_reset_sleep) else $error("sleeping during reset");
    property p_stretch;
        $fell(core_reset) |-> hi_len >= 6'd16;
    endproperty
    a_stretch: assert property (p_stretch) else $error("internal reset too short");
endmodule

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
    localparam logic [5:0] SC = pwr_pkg::SLEEP_CONTROL_ADDR;
    localparam logic [5:0] PG = pwr_pkg::POWER_GATING_ADDR;
    localparam logic [5:0] MC = pwr_pkg::MCU_CONTROL_ADDR;
    localparam logic [5:0] FL = pwr_pkg::RESET_CAUSE_ADDR;
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, port_rst, int_rst, slp, bod_off, adc_free;
    logic por = 1'b0, ext_n = 1'b1, wdt_exp = 1'b0, wdt_en = 1'b0;
    logic bod_low = 1'b0, bod_en = 1'b0, jtag = 1'b0, wake = 1'b0;
    logic [1:0] st_sel = 2'd0;
    logic [3:0] cs_sel = 4'd3;
    logic [2:0] slp_mode;
    wire [4:0] gates;
    // Source pattern {por, ext_n, wdt_exp, wdt_en, bod_low, bod_en, jtag} and the flag it leaves
    logic [6:0] src [7] = '{7'h00, 7'h38, 7'h30, 7'h26, 7'h24, 7'h21, 7'h60};
    logic [7:0] fl [7] = '{8'h02, 8'h08, 8'h00, 8'h04, 8'h00, 8'h10, 8'h01};
    int fails = 0, checks = 0, seed = 32'hd699;
    always #10 clk = ~clk;
    pwr_link_if link ();
    pwr_core pwr_core_i (.MCLK_IN(clk), .SRST_IN(srst), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .link(link));
    pwr_device pwr_device_i (.MCLK_IN(clk), .SRST_IN(srst), .link(link), .POR_IN(por),
        .EXT_RESET_N_IN(ext_n), .WDT_EXPIRE_IN(wdt_exp), .WDT_ENABLE_IN(wdt_en), .BOD_LOW_IN(bod_low),
        .BOD_ENABLE_IN(bod_en), .JTAG_RESET_IN(jtag), .STARTUP_TIME_SELECT_IN(st_sel),
        .CLOCK_SOURCE_SELECT_IN(cs_sel), .WAKE_IN(wake), .PORT_RESET_OUT(port_rst),
        .INT_RESET_OUT(int_rst), .SLEEP_OUT(slp), .SLEEP_MODE_OUT(slp_mode), .BOD_OFF_OUT(bod_off),
        .LCD_GATE_OUT(gates[4]), .TIMER1_GATE_OUT(gates[3]), .SPI_GATE_OUT(gates[2]),
        .USART_GATE_OUT(gates[1]), .ADC_GATE_OUT(gates[0]), .ADC_MUX_FREE_OUT(adc_free));
    pwr_checker pwr_checker_i (.MCLK_IN(clk), .SRST_IN(srst), .io_addr(link.io_addr),
        .io_wdata(link.io_wdata), .io_we(link.io_we), .io_re(link.io_re), .io_rdata(link.io_rdata),
        .sleep_exec(link.sleep_exec), .sleeping(link.sleeping), .core_reset(link.core_reset));
    function automatic int tout(input logic [1:0] s, input logic [3:0] c);
        return (16 + int'(c)) << s;
    endfunction
    function automatic logic ok_mode(input int m);
        return m inside {0, 1, 2, 3, 6};
    endfunction
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input logic [2:0] op, input logic [5:0] a, input logic [7:0] d, input logic [2:0] m);
        logic [31:0] q;
        logic e;
        apb(1'b1, pwr_pkg::CMD_OFFSET, {9'h000, m, 1'b0, op, d, 2'b00, a}, q, e);
    endtask
    task automatic wait_idle(output logic [31:0] s);
        logic e;
        for (int i = 0; i < 40; i++)
        begin
            apb(1'b0, pwr_pkg::STATUS_OFFSET, 32'h0, s, e);
            if (s[0] === 1'b0)
                break;
        end
        chk("idle", 0, s[0]);
    endtask
    task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] s;
        cmd(pwr_pkg::OP_WRITE, a, d, 3'd0);
        wait_idle(s);
    endtask
    task automatic io_rd(input logic [5:0] a, output logic [7:0] v);
        logic [31:0] s;
        cmd(pwr_pkg::OP_READ, a, 8'h00, 3'd0);
        wait_idle(s);
        v = s[15:8];
    endtask
    task automatic wait_rst(output int n);
        n = 0;
        while (int_rst !== 1'b0 && n < 1000)
        begin
            @(posedge clk);
            n++;
        end
        chk("reset release", 0, int_rst);
    endtask
    task automatic close_out;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        logic [7:0] v;
        logic [7:0] r;
        logic [31:0] q;
        logic e;
        int n;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        wait_rst(n);
        chk("srst stretch", 1, n >= 16);
        io_rd(SC, v);
        chk("sleep_control reset", 8'h00, v);
        io_rd(PG, v);
        chk("power_gating reset", 8'h00, v);
        io_rd(MC, v);
        chk("mcu_control reset", 8'h00, v);
        apb(1'b0, 8'h08, 32'h0, q, e);
        chk("unmapped error", 1, e);
        chk("unmapped data", 0, q);
        $display("reset test done");
        // Registers and gates, with both all-ones and all-zero corners
        for (int i = 0; i < 16; i++)
        begin
            v = (i == 0) ? 8'hff : ((i == 1) ? 8'h00 : 8'($random(seed)));
            io_wr(SC, v);
            io_rd(SC, r);
            chk("sleep_control", v & 8'h0f, r);
            io_wr(PG, v);
            io_rd(PG, r);
            chk("power_gating", v & 8'h1f, r);
            chk("gates", v[4:0], gates);
            chk("adc mux free", !v[0], adc_free);
        end
        $display("register test done");
        // Every mode code, reserved ones included
        for (int md = 0; md < 8; md++)
        begin
            cmd(pwr_pkg::OP_SLEEP, SC, 8'h00, 3'(md));
            n = 0;
            while (slp !== 1'b1 && n < 12)
            begin
                @(posedge clk);
                n++;
            end
            chk("sleeping", ok_mode(md), slp);
            if (ok_mode(md))
                chk("sleep mode", md, slp_mode);
            chk("bod off", 0, bod_off);
            wake <= 1'b1;
            @(posedge clk);
            wake <= 1'b0;
            wait_idle(q);
            io_rd(SC, v);
            if (ok_mode(md))
                chk("disarmed", 8'(md * 2), v);
        end
        $display("sleep test done");
        io_wr(MC, 8'hdf);
        io_rd(MC, v);
        chk("sleep-off locked", 8'h9f, v);
        cmd(pwr_pkg::OP_BROWNOUT_SLEEP_OFF, MC, 8'h11, 3'd0);
        wait_idle(q);
        io_rd(MC, v);
        chk("sleep-off expired", 8'h11, v);
        $display("sleep-off test done");
        // Flags are not cleared before the power-on case, which must clear them itself
        for (int k = 0; k < 7; k++)
        begin
            if (k != 6)
                io_wr(FL, 8'h00);
            io_wr(PG, 8'h1f);
            {por, ext_n, wdt_exp, wdt_en, bod_low, bod_en, jtag} <= src[k];
            @(posedge clk);
            chk("port reset", fl[k] != 8'h00, port_rst);
            repeat (4) @(posedge clk);
            chk("internal reset", fl[k] != 8'h00, int_rst);
            {por, ext_n, wdt_exp, wdt_en, bod_low, bod_en, jtag} <= 7'h20;
            wait_rst(n);
            if (fl[k] != 8'h00)
                chk("source stretch", 1, n >= tout(st_sel, cs_sel));
            io_rd(PG, v);
            chk("gating after reset", (fl[k] != 8'h00) ? 8'h00 : 8'h1f, v);
            io_rd(FL, v);
            chk("cause flags", fl[k], v);
        end
        $display("reset source test done");
        close_out();
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        fails++;
        close_out();
    end
endmodule
